// File: verilog/gpo_pkg.sv
// package for the port output/input register block
package gpo_pkg;
	localparam int           GPO_W          = 32;
	localparam int           GPO_GROUP      = 8;
	localparam int           GPO_NGROUP     = GPO_W / GPO_GROUP;
	localparam logic [7:0]   OFF_OUT_VALUE  = 8'h10;
	localparam logic [7:0]   OFF_OUT_CLEAR  = 8'h14;
	localparam logic [7:0]   OFF_OUT_SET    = 8'h18;
	localparam logic [7:0]   OFF_OUT_TOGGLE = 8'h1c;
	localparam logic [7:0]   OFF_IN_VALUE   = 8'h20;
	localparam logic [7:0]   OFF_SAMP_CTRL  = 8'h24;
	localparam logic [31:0]  RST_OUT_VALUE  = 32'h0000_0000;
	localparam logic [31:0]  RST_SAMP_CTRL  = 32'h0000_0000;
	localparam logic [31:0]  RST_IN_VALUE   = 32'h0000_0000;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} gpo_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} gpo_apb_rsp_t;

	typedef enum logic [1:0] {
		GPO_IDLE   = 2'b01,
		GPO_ACCESS = 2'b10
	} gpo_state_t;
endpackage

// File: verilog/gpo_sampler.sv
// input samplers switched per byte-wide sub-group
`timescale 1ns/1ps
`default_nettype none
module gpo_sampler
	import gpo_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic [GPO_W-1:0] pins_i,
	input  wire logic [GPO_W-1:0] samp_ctrl_i,
	output logic      [GPO_W-1:0] in_value_o
);
	logic [GPO_W-1:0] sync1_q, sync1_d;
	logic [GPO_W-1:0] in_q, in_d;
	logic [GPO_W-1:0] grp_en;

	// any set bit in a byte turns the whole byte on
	function automatic logic [GPO_W-1:0] byte_spread(input logic [GPO_W-1:0] v);
		logic [GPO_W-1:0] r;
		r = '0;
		for (int g = 0; g < GPO_NGROUP; g++) begin
			r[g*GPO_GROUP +: GPO_GROUP] = {GPO_GROUP{|v[g*GPO_GROUP +: GPO_GROUP]}};
		end
		return r;
	endfunction

	always_comb begin
		grp_en = byte_spread(samp_ctrl_i);
		// a disabled sampler holds its last value; saves toggling power
		sync1_d = (pins_i & grp_en) | (sync1_q & ~grp_en);
		in_d    = (sync1_q & grp_en) | (in_q & ~grp_en);
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sync1_q <= RST_IN_VALUE;
			in_q    <= RST_IN_VALUE;
		end else begin
			sync1_q <= sync1_d;
			in_q    <= in_d;
		end
	end

	assign in_value_o = in_q;
endmodule
`default_nettype wire

// File: verilog/gpo_port.sv
// port output value, pull direction and input sampling registers on apb
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - writing output_clear clears each output bit written one, others unchanged
// - output_clear on a pulled input selects pull-down
// - writing output_set at 0x18 sets each output bit written one
// - output_set on a pulled input selects pull-up
// - writing output_toggle at 0x1c inverts each output bit written one
// - output_toggle on a pulled input swaps pull-up and pull-down
// - value, set, clear and toggle registers all read the one output state
// - input_value at 0x20 reads the sampled pin levels
// - sampling control at 0x24 enables each pin's input synchronizer
// - samplers switch per byte: any enabled bit enables all eight
// - output value: zero drives low or pulls down, one high or up
module gpo_port
	import gpo_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             psel_i,
	input  wire logic             penable_i,
	input  wire logic             pwrite_i,
	input  wire logic [7:0]       paddr_i,
	input  wire logic [31:0]      pwdata_i,
	output logic      [31:0]      prdata_o,
	output logic                  pready_o,
	output logic                  pslverr_o,
	input  wire logic [GPO_W-1:0] pins_i,
	output logic      [GPO_W-1:0] out_value_o,
	output logic      [GPO_W-1:0] samp_ctrl_o
);
	gpo_apb_req_t     req;
	gpo_apb_rsp_t     rsp_q, rsp_d;
	gpo_state_t       st_q, st_d;
	logic [GPO_W-1:0] out_q, out_d;
	logic [GPO_W-1:0] samp_q, samp_d;
	logic [GPO_W-1:0] in_value;
	logic             wr_ok;

	function automatic logic addr_known(input logic [7:0] a);
		return a == OFF_OUT_VALUE || a == OFF_OUT_CLEAR || a == OFF_OUT_SET ||
		       a == OFF_OUT_TOGGLE || a == OFF_IN_VALUE || a == OFF_SAMP_CTRL;
	endfunction

	assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
	               paddr: paddr_i, pwdata: pwdata_i};

	gpo_sampler u_sampler (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.pins_i      (pins_i),
		.samp_ctrl_i (samp_q),
		.in_value_o  (in_value)
	);

	// one wait state: setup, one access cycle with pready low, then a second where pready rises
	always_comb begin
		st_d  = st_q;
		rsp_d = '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
		wr_ok = 1'b0;
		case (st_q)
			GPO_IDLE: begin
				if (req.psel && req.penable) begin
					st_d         = GPO_ACCESS;
					rsp_d.pready = 1'b1;
					rsp_d.pslverr = ~addr_known(req.paddr);
					if (!req.pwrite) begin
						case (req.paddr)
							OFF_OUT_VALUE, OFF_OUT_CLEAR,
							OFF_OUT_SET, OFF_OUT_TOGGLE: rsp_d.prdata = out_q;
							OFF_IN_VALUE:  rsp_d.prdata = in_value;
							OFF_SAMP_CTRL: rsp_d.prdata = samp_q;
							default:       rsp_d.prdata = 32'h0000_0000;
						endcase
					end
				end
			end
			GPO_ACCESS: begin
				// the write lands on the edge where the master sees pready
				st_d  = GPO_IDLE;
				wr_ok = req.psel && req.penable && req.pwrite;
			end
			default: st_d = GPO_IDLE;
		endcase
	end

	// pull direction of pulled inputs is the same bit, so set/clear/toggle steer it too
	always_comb begin
		out_d  = out_q;
		samp_d = samp_q;
		if (wr_ok) begin
			case (req.paddr)
				OFF_OUT_VALUE:  out_d  = req.pwdata;
				OFF_OUT_CLEAR:  out_d  = out_q & ~req.pwdata;
				OFF_OUT_SET:    out_d  = out_q | req.pwdata;
				OFF_OUT_TOGGLE: out_d  = out_q ^ req.pwdata;
				OFF_SAMP_CTRL:  samp_d = req.pwdata;
				default:        out_d  = out_q;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q   <= GPO_IDLE;
			rsp_q  <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
			out_q  <= RST_OUT_VALUE;
			samp_q <= RST_SAMP_CTRL;
		end else begin
			st_q   <= st_d;
			rsp_q  <= rsp_d;
			out_q  <= out_d;
			samp_q <= samp_d;
		end
	end

	assign prdata_o    = rsp_q.prdata;
	assign pready_o    = rsp_q.pready;
	assign pslverr_o   = rsp_q.pslverr;
	assign out_value_o = out_q;
	assign samp_ctrl_o = samp_q;
endmodule
`default_nettype wire

// File: dv/gpo_port_sva.sv
// checker for the port register block
`timescale 1ns/1ps
`default_nettype none
module gpo_port_chk
	import gpo_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic [31:0] out_value_o,
	input wire logic [31:0] samp_ctrl_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// only a completed access commits, a waiting setup must not
	wire logic        w = psel_i && penable_i && pwrite_i && pready_o;
	wire logic [7:0]  a = paddr_i;
	wire logic [31:0] q = out_value_o;
	wire logic [31:0] d = pwdata_i;
	clr_bits_a: assert property (w && a == 8'h14
		|=> q == ($past(q) & ~$past(d))) else $error("clear wrong");
	set_bits_a: assert property (w && a == 8'h18
		|=> q == ($past(q) | $past(d))) else $error("set wrong");
	tgl_bits_a: assert property (w && a == 8'h1c
		|=> q == ($past(q) ^ $past(d))) else $error("toggle wrong");
	out_store_a: assert property (w && a == 8'h10
		|=> q == $past(d)) else $error("store wrong");
	// unaligned offsets are unmapped and read zero, so only whole-word offsets count
	one_state_a: assert property (pready_o && !pwrite_i && a[7:4] == 4'h1 && a[1:0] == 2'b00
		|-> prdata_o == q) else $error("readback wrong");
	in_ro_a: assert property (w && a == 8'h20
		|=> $stable(q) && $stable(samp_ctrl_o)) else $error("input written");
	ctrl_wr_a: assert property (w && a == 8'h24
		|=> samp_ctrl_o == $past(d)) else $error("control wrong");
	rdy_once_a: assert property (pready_o |=> !pready_o) else $error("ready stuck");
	cover property (w && a == 8'h1c);
	cover property (w && a == 8'h24);
	cover property (pready_o && !pwrite_i);
endmodule
bind gpo_port gpo_port_chk chk_u (
	.clk_i       (clk_i),
	.rstn_i      (rstn_i),
	.psel_i      (psel_i),
	.penable_i   (penable_i),
	.pwrite_i    (pwrite_i),
	.paddr_i     (paddr_i),
	.pwdata_i    (pwdata_i),
	.prdata_o    (prdata_o),
	.pready_o    (pready_o),
	.out_value_o (out_value_o),
	.samp_ctrl_o (samp_ctrl_o)
);
`default_nettype wire

// File: dv/gpo_port_bench.sv
// bench for the port register block
`timescale 1ns/1ps
`default_nettype none
module gpo_port_bench import gpo_pkg::*;;
	logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o, pins_i, out_value_o, samp_ctrl_o, rd;
	int          n_mismatch = 0, checked = 0;
	gpo_port dut_u (
		.clk_i       (clk_i),
		.rstn_i      (rstn_i),
		.psel_i      (psel_i),
		.penable_i   (penable_i),
		.pwrite_i    (pwrite_i),
		.paddr_i     (paddr_i),
		.pwdata_i    (pwdata_i),
		.prdata_o    (prdata_o),
		.pready_o    (pready_o),
		.pslverr_o   (pslverr_o),
		.pins_i      (pins_i),
		.out_value_o (out_value_o),
		.samp_ctrl_o (samp_ctrl_o)
	);
	initial begin
		clk_i = 0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic stop_test;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// waits on pready with no limit of its own; the watchdog ends a hang
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	initial begin
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pins_i, rstn_i} = '0;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		rdc(8'h10, 32'h0000_0000);
		rdc(8'h24, 32'h0000_0000);
		xfer(1'b1, 8'h10, 32'h1234_5678);
		chk(out_value_o, 32'h1234_5678);
		xfer(1'b1, 8'h18, 32'hffff_0000);
		chk(out_value_o, 32'hffff_5678);
		rdc(8'h10, 32'hffff_5678);
		xfer(1'b1, 8'h14, 32'h0f0f_0000);
		chk(out_value_o, 32'hf0f0_5678);
		rdc(8'h14, 32'hf0f0_5678);
		xfer(1'b1, 8'h1c, 32'h0000_00ff);
		chk(out_value_o, 32'hf0f0_5687);
		rdc(8'h1c, 32'hf0f0_5687);
		xfer(1'b1, 8'h20, 32'hffff_ffff);
		chk({31'h0, er}, 32'h0000_0000);
		rdc(8'h18, 32'hf0f0_5687);
		// an unmapped write is refused with an error and leaves the state alone
		xfer(1'b1, 8'h40, 32'hffff_ffff);
		chk({31'h0, er}, 32'h0000_0001);
		chk(out_value_o, 32'hf0f0_5687);
		pins_i <= 32'ha5a5_a5a5;
		xfer(1'b1, 8'h24, 32'h0000_0100);
		chk(samp_ctrl_o, 32'h0000_0100);
		repeat (3) @(posedge clk_i);
		rdc(8'h20, 32'h0000_a500);
		xfer(1'b1, 8'h24, 32'h0100_0000);
		pins_i <= 32'h3c3c_3c3c;
		repeat (3) @(posedge clk_i);
		rdc(8'h20, 32'h3c00_a500);
		rdc(8'h40, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
		// reset in mid-run: state and sampling enables go back to zero
		rstn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(out_value_o, 32'h0000_0000);
		chk(samp_ctrl_o, 32'h0000_0000);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		rdc(8'h1c, 32'h0000_0000);
		rdc(8'h24, 32'h0000_0000);
		// samplers stay off after reset, so the input value holds its reset level
		rdc(8'h20, 32'h0000_0000);
		stop_test;
	end
	initial begin
		#20000;
		n_mismatch++;
		stop_test;
	end
endmodule
`default_nettype wire
